/* File: core/pmc_defs.svh */
// Purpose: register offsets, field positions, reset values and counts
//          for the prescaled 40-bit match counter
// Assumes: byte-wide register port, one byte per address
// Notes:   definitions only
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// register windows (byte addresses)
`define PMC_ADDR_CNT_BASE   8'h00
`define PMC_ADDR_MATCH_BASE 8'h08
`define PMC_ADDR_MBITS_BASE 8'h10
`define PMC_ADDR_CTRL       8'h18
`define PMC_ADDR_ISTAT      8'h19
`define PMC_ADDR_IMASK      8'h1A

// bytes in one 40-bit window
`define PMC_WIN_BYTES       8'h05

// control and status register fields
`define PMC_CTRL_AUTOCLR    0
`define PMC_CTRL_MODE_LO    1
`define PMC_CTRL_MODE_HI    2
`define PMC_CTRL_XTAL_EN    3
`define PMC_CTRL_RUN        4
`define PMC_CTRL_MATCH      7

// interrupt status / mask fields
`define PMC_IRQ_MATCH       0
`define PMC_IRQ_WRAP        1

// reset values
`define PMC_CTRL_RST        8'h00
`define PMC_MASK_RST        8'h00
`define PMC_COUNT_RST       40'h00_0000_0000
`define PMC_MATCH_RST       40'h00_0000_0000

// prescaler divide ratio
`define PMC_PRESCALE        128

`endif

/* File: core/pmc_pkg.sv */
// Purpose: shared types of the prescaled 40-bit match counter
// Assumes: nothing
// Notes:   constants live in pmc_defs.svh
`default_nettype none
package pmc_pkg;
  typedef logic [39:0] pmc_count_t; // 40-bit count or match word
  typedef logic [7:0] pmc_byte_t;   // one register byte
  typedef logic [2:0] pmc_idx_t;    // byte index inside a window
endpackage : pmc_pkg
`default_nettype wire

/* File: core/pmc_prescaler.sv */
// Purpose: synchronise the timekeeper clock pin and divide it
// Assumes: pin clock well below half of sys_clk_i
// Notes:   one tick pulse every DIV rising edges of the pin clock
`timescale 1ns/1ps
`default_nettype none
module pmc_prescaler #(
  parameter int DIV = 128
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic pin_clk_i,
  output logic tick_o
);

  localparam int W = $clog2(DIV);

  logic sync1_r; // first stage, read only by sync2_r
  logic sync2_r; // stable copy of the pin
  logic prev_r;  // last stable level, for edge detect
  logic [W-1:0] div_r;
  logic edge_w;

  // two-flop synchroniser then one more stage for the edge
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= pin_clk_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign edge_w = sync2_r & ~prev_r;

  // divide by DIV: tick on the last edge of each group
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (edge_w) begin
        if (div_r == W'(DIV - 1)) begin
          div_r <= '0;
          tick_o <= 1'b1;
        end else begin
          div_r <= div_r + W'(1);
        end
      end
    end
  end

endmodule : pmc_prescaler
`default_nettype wire

/* File: core/pmc_counter.sv */
// Purpose: 40-bit loadable timekeeping counter with match compare
// Assumes: byte register port; timekeeper clock arrives on a pin
// Notes:   count advances only from the prescaled pin clock
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"

// Summary of operation
// - loadable counter forty bits wide
// - advance only on pin clock divided 128
// - software preloads count before counting starts
// - count reads back at load addresses
// - multi-byte reads come from hold register
// - match flag high exactly while count equals match
// - sequencer match copies match flag
// - match bits read all ones on match
// - auto-clear zeroes count on match
// - no auto-clear when match value zero
// - crystal mode output follows control field
// - crystal select follows crystal enable bit
// - one data byte per address
module pmc_counter #(
  parameter int PRESCALE = `PMC_PRESCALE
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // timekeeper clock from the crystal oscillator output
  input wire logic timekeeper_clock_in_i,
  // oscillator controls
  output logic [1:0] crystal_mode_out_o,
  output logic crystal_select_out_o,
  // match outputs to fabric and power sequencer
  output logic match_flag_out_o,
  output logic sequencer_match_out_o,
  // level interrupt
  output logic irq_o
);

  // ---------------------------------------------------------------
  // window decode helpers
  // ---------------------------------------------------------------

  // true when the address falls in the five-byte window at base
  function automatic logic in_win(input logic [7:0] addr,
                                  input logic [7:0] base);
    logic [7:0] off;
    off = addr - base;
    in_win = (addr >= base) && (off < `PMC_WIN_BYTES);
  endfunction : in_win

  // byte index inside a window, valid only when in_win holds
  function automatic pmc_pkg::pmc_idx_t win_idx(
      input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] off;
    off = addr - base;
    win_idx = off[2:0];
  endfunction : win_idx

  // pick one byte of a 40-bit word
  function automatic pmc_pkg::pmc_byte_t get_byte(
      input pmc_pkg::pmc_count_t word, input pmc_pkg::pmc_idx_t idx);
    pmc_pkg::pmc_byte_t b;
    b = 8'h00;
    for (int i = 0; i < 5; i++) begin
      if (idx == 3'(i)) begin
        b = word[i*8 +: 8];
      end
    end
    get_byte = b;
  endfunction : get_byte

  // replace one byte of a 40-bit word
  function automatic pmc_pkg::pmc_count_t put_byte(
      input pmc_pkg::pmc_count_t word, input pmc_pkg::pmc_idx_t idx,
      input pmc_pkg::pmc_byte_t b);
    pmc_pkg::pmc_count_t w;
    w = word;
    for (int i = 0; i < 5; i++) begin
      if (idx == 3'(i)) begin
        w[i*8 +: 8] = b;
      end
    end
    put_byte = w;
  endfunction : put_byte

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pmc_pkg::pmc_count_t count_r;  // live count
  pmc_pkg::pmc_count_t count_nxt;
  pmc_pkg::pmc_count_t match_r;  // stored match value
  pmc_pkg::pmc_count_t match_nxt;
  pmc_pkg::pmc_count_t hold_r;   // read-hold copy of the count
  pmc_pkg::pmc_byte_t ctrl_r;    // control bits, match bit is live
  pmc_pkg::pmc_byte_t istat_r;   // sticky event bits
  pmc_pkg::pmc_byte_t imask_r;   // interrupt enables
  pmc_pkg::pmc_byte_t rdata_r;   // read answer
  logic hit_r;                   // count equals match value
  logic hit_d_r;                 // hit_r one cycle ago
  logic irq_r;

  // decoded accesses
  logic cnt_wr_w;
  logic cnt_rd_w;
  logic match_wr_w;
  logic tick_w;
  logic clr_hit_w;
  logic wrap_w;
  logic ev_match_w;
  pmc_pkg::pmc_idx_t idx_cnt_w;
  pmc_pkg::pmc_idx_t idx_match_w;
  pmc_pkg::pmc_byte_t istat_set_w;

  // ---------------------------------------------------------------
  // prescaler: synchronises the pin and divides it
  // ---------------------------------------------------------------
  pmc_prescaler #(
    .DIV(PRESCALE)
  ) u_prescaler (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .pin_clk_i(timekeeper_clock_in_i),
    .tick_o(tick_w)
  );

  // ---------------------------------------------------------------
  // address decode, one byte per address
  // ---------------------------------------------------------------
  assign idx_cnt_w = win_idx(reg_addr_i, `PMC_ADDR_CNT_BASE);
  assign idx_match_w = win_idx(reg_addr_i, `PMC_ADDR_MATCH_BASE);
  assign cnt_wr_w = reg_wr_i && in_win(reg_addr_i, `PMC_ADDR_CNT_BASE);
  assign cnt_rd_w = reg_rd_i && in_win(reg_addr_i, `PMC_ADDR_CNT_BASE);
  assign match_wr_w = reg_wr_i &&
                      in_win(reg_addr_i, `PMC_ADDR_MATCH_BASE);

  // auto-clear fires while matched, enabled and match value nonzero
  assign clr_hit_w = hit_r && ctrl_r[`PMC_CTRL_AUTOCLR] &&
                     (match_r != `PMC_MATCH_RST);

  // wrap from all ones is an event only when nothing clears first
  assign wrap_w = tick_w && ctrl_r[`PMC_CTRL_RUN] && !clr_hit_w &&
                  (count_r == ~`PMC_COUNT_RST);

  // match event on the rising edge of the compare
  assign ev_match_w = hit_r && !hit_d_r;

  // ---------------------------------------------------------------
  // next count: load beats auto-clear beats increment
  // ---------------------------------------------------------------
  always_comb begin : count_next
    count_nxt = count_r;
    if (clr_hit_w) begin
      count_nxt = `PMC_COUNT_RST;
    end else if (tick_w && ctrl_r[`PMC_CTRL_RUN]) begin
      // plain add wraps all ones to zero on its own
      count_nxt = count_r + 40'h00_0000_0001;
    end
    if (cnt_wr_w) begin
      // a byte write preloads that byte of the live count
      count_nxt = put_byte(count_nxt, idx_cnt_w, reg_wdata_i);
    end
  end

  // next match value from byte writes
  always_comb begin : match_next
    match_nxt = match_r;
    if (match_wr_w) begin
      match_nxt = put_byte(match_r, idx_match_w, reg_wdata_i);
    end
  end

  // count register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_r <= `PMC_COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // match value register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      match_r <= `PMC_MATCH_RST;
    end else begin
      match_r <= match_nxt;
    end
  end

  // compare on next values so the flag tracks the count with no lag;
  // both reset to zero, so the flag starts high
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hit_r <= 1'b1;
      hit_d_r <= 1'b1;
    end else begin
      hit_r <= (count_nxt == match_nxt);
      hit_d_r <= hit_r;
    end
  end

  assign match_flag_out_o = hit_r;
  assign sequencer_match_out_o = hit_r;

  // ---------------------------------------------------------------
  // read-hold register
  // ---------------------------------------------------------------
  // reading the low byte snapshots the whole count, so the upper
  // bytes read afterwards belong to the same instant even if a
  // tick lands between the byte reads
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_r <= `PMC_COUNT_RST;
    end else if (cnt_rd_w && idx_cnt_w == 3'h0) begin
      hold_r <= count_r;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // bit 7 is the live match state and is not stored here
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= `PMC_CTRL_RST;
    end else if (reg_wr_i && reg_addr_i == `PMC_ADDR_CTRL) begin
      ctrl_r <= reg_wdata_i & 8'h1F;
    end
  end

  // oscillator controls straight from stored bits
  assign crystal_mode_out_o =
    ctrl_r[`PMC_CTRL_MODE_HI:`PMC_CTRL_MODE_LO];
  assign crystal_select_out_o = ctrl_r[`PMC_CTRL_XTAL_EN];

  // ---------------------------------------------------------------
  // interrupt status, mask and output
  // ---------------------------------------------------------------
  always_comb begin : irq_events
    istat_set_w = 8'h00;
    istat_set_w[`PMC_IRQ_MATCH] = ev_match_w;
    istat_set_w[`PMC_IRQ_WRAP] = wrap_w;
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      istat_r <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == `PMC_ADDR_ISTAT) begin
      istat_r <= (istat_r & ~reg_wdata_i) | istat_set_w;
    end else begin
      istat_r <= istat_r | istat_set_w;
    end
  end

  // mask register, only the two event bits exist
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      imask_r <= `PMC_MASK_RST;
    end else if (reg_wr_i && reg_addr_i == `PMC_ADDR_IMASK) begin
      imask_r <= reg_wdata_i & 8'h03;
    end
  end

  // registered level, one cycle behind the status bits
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(istat_r & imask_r);
    end
  end

  assign irq_o = irq_r;

  // ---------------------------------------------------------------
  // read data, valid the cycle after the strobe only
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 8'h00;
    end else if (!reg_rd_i) begin
      // zero outside the answer cycle keeps the bus quiet
      rdata_r <= 8'h00;
    end else if (in_win(reg_addr_i, `PMC_ADDR_CNT_BASE)) begin
      if (idx_cnt_w == 3'h0) begin
        // low byte comes live, same value the hold captures
        rdata_r <= count_r[7:0];
      end else begin
        rdata_r <= get_byte(hold_r, idx_cnt_w);
      end
    end else if (in_win(reg_addr_i, `PMC_ADDR_MATCH_BASE)) begin
      rdata_r <= get_byte(match_r, idx_match_w);
    end else if (in_win(reg_addr_i, `PMC_ADDR_MBITS_BASE)) begin
      // every match bit reads one while matched
      rdata_r <= {8{hit_r}};
    end else if (reg_addr_i == `PMC_ADDR_CTRL) begin
      rdata_r <= {hit_r, ctrl_r[6:0]};
    end else if (reg_addr_i == `PMC_ADDR_ISTAT) begin
      rdata_r <= istat_r;
    end else if (reg_addr_i == `PMC_ADDR_IMASK) begin
      rdata_r <= imask_r;
    end else begin
      // unmapped address reads zero
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule : pmc_counter
`default_nettype wire

/* File: dv/pmc_counter_chk.sv */
// Purpose: port assertions for pmc_counter
// Assumes: one clock domain, async active-low reset
// Notes: bound into every pmc_counter instance
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_counter_chk #(
  parameter int PRESCALE = 128
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic timekeeper_clock_in_i,
  input wire logic [1:0] crystal_mode_out_o,
  input wire logic crystal_select_out_o,
  input wire logic match_flag_out_o,
  input wire logic sequencer_match_out_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // control byte written this cycle
  sequence ctrl_wr_s;
    reg_wr_i && reg_addr_i == `PMC_ADDR_CTRL;
  endsequence
  // read aimed at the match bits window
  sequence mbits_rd_s;
    reg_rd_i && reg_addr_i >= `PMC_ADDR_MBITS_BASE &&
      reg_addr_i < `PMC_ADDR_MBITS_BASE + `PMC_WIN_BYTES;
  endsequence
  seq_copy_a: assert property (
    sequencer_match_out_o == match_flag_out_o) else $error("copy differs");
  mode_follow_a: assert property (
    ctrl_wr_s |=> crystal_mode_out_o == $past(reg_wdata_i[2:1]))
    else $error("mode not taken");
  sel_follow_a: assert property (
    ctrl_wr_s |=> crystal_select_out_o == $past(reg_wdata_i[3]))
    else $error("select not taken");
  ctl_hold_a: assert property (
    !(reg_wr_i && reg_addr_i == `PMC_ADDR_CTRL) |=>
    $stable({crystal_mode_out_o, crystal_select_out_o}))
    else $error("controls moved");
  rdata_idle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("rdata not idle");
  mbits_set_a: assert property (
    mbits_rd_s ##0 match_flag_out_o |=> reg_rdata_o == 8'hFF)
    else $error("match bits not ones");
  mbits_clr_a: assert property (
    mbits_rd_s ##0 !match_flag_out_o |=> reg_rdata_o == 8'h00)
    else $error("match bits not zero");
  match_bit_a: assert property (
    reg_rd_i && reg_addr_i == `PMC_ADDR_CTRL |=>
    reg_rdata_o[7] == $past(match_flag_out_o)) else $error("match bit");
  irq_mask_a: assert property (
    reg_wr_i && reg_addr_i == `PMC_ADDR_IMASK && reg_wdata_i[1:0] == 2'b00
    |=> ##1 !irq_o) else $error("masked irq high");
endmodule : pmc_counter_chk
bind pmc_counter pmc_counter_chk #(.PRESCALE(PRESCALE)) u_chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .timekeeper_clock_in_i(timekeeper_clock_in_i),
  .crystal_mode_out_o(crystal_mode_out_o),
  .crystal_select_out_o(crystal_select_out_o),
  .match_flag_out_o(match_flag_out_o),
  .sequencer_match_out_o(sequencer_match_out_o), .irq_o(irq_o));
`default_nettype wire

/* File: dv/pmc_xtal_model.sv */
// Purpose: crystal oscillator clock source for the timekeeper pin
// Assumes: oscillator runs only while the counter selects it
// Notes: parks low when stopped so no stray edge is counted
`timescale 1ns/1ps
`default_nettype none
module pmc_xtal_model #(
  parameter int HALF_NS = 33
) (
  input wire logic sel_i,
  input wire logic en_i,
  output logic clk_o
);
  // half period not a multiple of 10 ns: phase drifts against sys clock
  initial begin
    clk_o = 1'b0;
    forever begin
      #(HALF_NS);
      if (sel_i && en_i) begin
        clk_o = ~clk_o;
      end else begin
        clk_o = 1'b0;
      end
    end
  end
endmodule : pmc_xtal_model
`default_nettype wire

/* File: dv/test_pmc_counter.sv */
// Purpose: self-checking bench for pmc_counter
// Assumes: PRESCALE set to 4 so ticks come every four pin edges
// Notes: reset and tick checks first, then register table rows, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
module test_pmc_counter;
  localparam int PS = 4; // short prescale keeps the run brief
  logic clk, nrst, wr_s, rd_s, en, xclk, sel, mflag, smatch, irq;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] mode;
  int fail_count = 0;
  int tests_run = 0;
  // address, write data, expected read back
  logic [7:0] tab [6][3] = '{'{8'h08, 8'hA5, 8'hA5},
    '{8'h0C, 8'h5A, 8'h5A}, '{8'h1B, 8'hFF, 8'h00},
    '{8'h14, 8'h33, 8'h00}, '{8'h1A, 8'h02, 8'h02},
    '{8'h18, 8'h16, 8'h16}};
  pmc_counter #(.PRESCALE(PS)) dut (.sys_clk_i(clk), .nrst_i(nrst),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .timekeeper_clock_in_i(xclk),
    .crystal_mode_out_o(mode), .crystal_select_out_o(sel),
    .match_flag_out_o(mflag), .sequencer_match_out_o(smatch), .irq_o(irq));
  pmc_xtal_model u_xtal (.sel_i(sel), .en_i(en), .clk_o(xclk));
  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    // step off the edge so callers see the state the write launched
    #1;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // low byte first so the hold register is captured
  task automatic rd40(input logic [7:0] a, output logic [39:0] v);
    logic [7:0] b;
    for (int i = 0; i < 5; i++) begin
      rd(a + 8'(i), b);
      v[i*8 +: 8] = b;
    end
  endtask : rd40
  task automatic wr40(input logic [7:0] a, input logic [39:0] v);
    for (int i = 0; i < 5; i++) begin
      wr(a + 8'(i), v[i*8 +: 8]);
    end
  endtask : wr40
  // watchdog well beyond the expected thousand or so cycles
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    logic [7:0] b;
    logic [39:0] v;
    {nrst, wr_s, rd_s, addr, wdata} = '0;
    en = 1'b1;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({mode, sel, irq}, 40'h0);
    chk({mflag, smatch}, 40'h3);
    rd(8'h10, b);
    chk(b, 40'hFF);
    // exactly 14 pin edges give three ticks
    wr(8'h18, 8'h18);
    repeat (14) @(posedge xclk);
    en = 1'b0;
    repeat (20) @(posedge clk);
    rd40(8'h00, v);
    chk(v, 40'h3);
    for (int i = 0; i < 6; i++) begin
      wr(tab[i][0], tab[i][1]);
      rd(tab[i][0], b);
      chk(b, tab[i][2]);
    end
    chk({mode, sel}, 40'h6);
    // preload near wrap, then run and watch the hold register
    wr(8'h18, 8'h06);
    wr40(8'h00, 40'hFF_FFFF_FFFE);
    rd40(8'h00, v);
    chk(v, 40'hFF_FFFF_FFFE);
    wr40(8'h08, 40'h00_0000_0003);
    wr(8'h19, 8'hFF);
    wr(8'h18, 8'h1E);
    en = 1'b1;
    rd(8'h00, b);
    chk(b, 40'hFE);
    chk({mode, sel}, 40'h7);
    repeat (600) @(posedge clk);
    for (int i = 1; i < 5; i++) begin
      rd(8'(i), b);
      chk(b, 40'hFF);
    end
    rd40(8'h00, v);
    chk(v[39:8], 40'h0);
    chk(irq, 1'b1);
    rd(8'h19, b);
    chk(b & 8'h03, 40'h3);
    wr(8'h1A, 8'h00);
    @(posedge clk);
    #1 chk(irq, 1'b0);
    wr(8'h18, 8'h06);
    wr(8'h19, 8'h03);
    wr(8'h1A, 8'h03);
    rd(8'h19, b);
    chk(b, 40'h0);
    chk(irq, 1'b0);
    // auto-clear with a nonzero match value
    wr(8'h18, 8'h00);
    wr40(8'h00, 40'h0);
    wr40(8'h08, 40'h00_0000_0005);
    wr(8'h18, 8'h1D);
    chk(mode, 40'h2);
    for (int i = 0; i < 400 && mflag !== 1'b1; i++) @(negedge clk);
    chk(mflag, 1'b1);
    @(negedge clk);
    chk(mflag, 1'b0);
    rd(8'h00, b);
    chk(b, 40'h0);
    // a zero match value must not clear the count
    wr(8'h18, 8'h00);
    wr40(8'h08, 40'h0);
    wr40(8'h00, 40'h0);
    chk(mflag, 1'b1);
    wr(8'h18, 8'h1B);
    chk(mode, 40'h1);
    repeat (100) @(posedge clk);
    rd(8'h00, b);
    chk(b != 8'h00, 1'b1);
    chk(mflag, 1'b0);
    give_verdict();
  end
endmodule : test_pmc_counter
`default_nettype wire
